//--- logic/ltc_top.sv
// Temperature readout and piecewise-linear compensation of the LCD supply setting,
// plus multiplex and bias decode for the voltage selector.
// Assumes command decode elsewhere delivers write strobes synchronous to clk.
//
// Functional notes
// R01: Provide 8-bit sensor temperature code, T = 0.6275*code - 40, readable.
// R02: Temperature code is FFh after reset, meaning no measurement.
// R03: While measure enabled, measure once per second, each taking 8 ms.
// R04: Filter enable bit smooths temperature code at cost of delay.
// R05: Compensation enable bit switches supply compensation on or off.
// R06: Four limits split range into six regions, each with own slope.
// R07: Limit codes: lower limits 10..80 step 10, upper 110..208 step 14.
// R08: Slope codes map to 0,-1/8,-1/4,-1/2,-5/4,+1/8,+1/4,+1/2; reset 000.
// R09: No compensation unless limit one below two and three below four.
// R10: Codes up to 96 give negative sum of region spans times slopes.
// R11: Codes above 96 up to 231 sum spans times fourth, fifth, sixth slopes.
// R12: Selector configured by separate bias and multiplex commands.
// R13: Modes static, 1:2, 1:4, 1:6, 1:8, 1:9 with matching backplanes.
// R14: Bias half, third, quarter give 3, 4, 5 levels; static two.
// R15: Static drive used for a single backplane.
// R16: Two-backplane mode supports half and third bias.
// R17: Six-backplane mode supports third and quarter bias.
// R18: Offset is two's complement, zero at code 96, added to 9-bit setting.
// R19: External supply disables compensation regardless of enable bit.
// R20: Offset forced to zero when disabled or no valid code.
// R21: Offset rounded to signed integer of at least nine bits.
`timescale 1ns/1ns
module ltc_top
  import ltc_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC,
  parameter int unsigned CONV_CYCLES   = CONV_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control bits
  input  wire logic       measure_enable,
  input  wire logic       temp_filter_enable,
  input  wire logic       comp_enable,
  input  wire logic       ext_supply,
  // Limit command
  input  wire logic       set_limit_cmd,
  input  wire logic [1:0] set_limit_sel,
  input  wire logic [2:0] set_limit_code,
  // Slope command
  input  wire logic       set_slope_cmd,
  input  wire logic [2:0] set_slope_sel,
  input  wire logic [2:0] set_slope_code,
  // Voltage setting
  input  wire logic [8:0] volt_setting,
  // Selector commands
  input  wire logic       multiplex_select_cmd,
  input  wire logic [2:0] multiplex_mode,
  input  wire logic       bias_select_cmd,
  input  wire logic [1:0] bias_mode,
  // Sensor side
  input  wire logic [7:0] sensor_raw,
  output logic            sensor_start,
  // Temperature results
  output logic [7:0]      temp_code,
  output logic            temp_valid,
  output logic            meas_done,
  // Compensation results
  output logic [8:0]      comp_offset,
  output logic [9:0]      supply_target,
  output logic            comp_active,
  // Selector status
  output logic [3:0]      backplane_count,
  output logic [2:0]      drive_levels,
  output logic            static_drive,
  output logic            bias_illegal
);
  logic [2:0]  limit_code_q [4];
  logic [2:0]  slope_q [6];
  logic [2:0]  mux_q;
  logic [1:0]  bias_q;
  logic [7:0]  t1, t2, t3, t4;
  logic        limits_ok;
  logic signed [13:0] acc;
  logic signed [13:0] rnd;
  logic [8:0]  off_d, off_q;
  logic [9:0]  sum_d, sum_q;
  logic [3:0]  bp_d, bp_q;
  logic [2:0]  lv_d, lv_q;
  logic        ill_d, ill_q;
  logic        act_q;

  // Span (hi-lo) times slope code, result in eighths
  // Product kept at 14 bits: widest span times steepest slope overflows 10
  function automatic logic signed [13:0] span_mul(input logic [7:0] hi,
                                                  input logic [7:0] lo,
                                                  input logic [2:0] sel);
    logic signed [13:0] span;
    span = $signed({6'h00, hi}) - $signed({6'h00, lo});
    span_mul = span * 14'(COEF_TAB[sel]);                   // [R08]
  endfunction

  // Limit code to temperature code
  function automatic logic [7:0] lim_val(input logic [2:0] c, input logic upper);
    lim_val = upper ? 8'(HIGH_BASE + c * HIGH_STEP)         // [R07]
                    : 8'(LOW_BASE + c * LOW_STEP);          // [R07]
  endfunction

  // Measurement sequencer and filter
  ltc_sensor #(
    .PERIOD_CYCLES (PERIOD_CYCLES),
    .CONV_CYCLES   (CONV_CYCLES)
  ) u_sensor (
    .clk                (clk),
    .rst                (rst),
    .measure_enable     (measure_enable),
    .temp_filter_enable (temp_filter_enable),
    .sensor_raw         (sensor_raw),
    .sensor_start       (sensor_start),
    .temp_code          (temp_code),
    .temp_valid         (temp_valid),
    .meas_done          (meas_done)
  );

  // Limit registers written by limit command
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) limit_code_q[i] <= LIMIT_RESET;
    end else if (set_limit_cmd) begin
      limit_code_q[set_limit_sel] <= set_limit_code;        // [R07]
    end
  end

  // Slope registers, six independent selections
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) slope_q[i] <= SLOPE_RESET; // [R08]
    end else if (set_slope_cmd && set_slope_sel < 3'd6) begin
      slope_q[set_slope_sel] <= set_slope_code;             // [R06]
    end
  end

  // Selector configuration, separate commands
  always_ff @(posedge clk) begin
    if (rst) begin
      mux_q  <= MUX_RESET;
      bias_q <= BIAS_RESET;
    end else begin
      if (multiplex_select_cmd && multiplex_mode <= 3'd5)
        mux_q <= multiplex_mode;                            // [R12]
      if (bias_select_cmd && bias_mode <= 2'd2)
        bias_q <= bias_mode;                                // [R12]
    end
  end

  assign t1 = lim_val(limit_code_q[0], 1'b0);
  assign t2 = lim_val(limit_code_q[1], 1'b0);
  assign t3 = lim_val(limit_code_q[2], 1'b1);
  assign t4 = lim_val(limit_code_q[3], 1'b1);
  assign limits_ok = (t1 < t2) && (t3 < t4);                // [R09]

  // Piecewise-linear offset in eighths
  always_comb begin
    acc = 14'sh0;
    if (temp_code <= TEMP_MID) begin                        // [R10]
      if (temp_code > t2)
        acc = -span_mul(TEMP_MID, temp_code, slope_q[2]);
      else if (temp_code > t1)
        acc = -span_mul(TEMP_MID, t2, slope_q[2]) - span_mul(t2, temp_code, slope_q[1]);
      else
        acc = -span_mul(TEMP_MID, t2, slope_q[2]) - span_mul(t2, t1, slope_q[1])
              - span_mul(t1, temp_code, slope_q[0]);        // [R10]
    end else begin                                          // [R11]
      if (temp_code <= t3)
        acc = span_mul(temp_code, TEMP_MID, slope_q[3]);
      else if (temp_code <= t4)
        acc = span_mul(t3, TEMP_MID, slope_q[3]) + span_mul(temp_code, t3, slope_q[4]);
      else begin
        acc = span_mul(t3, TEMP_MID, slope_q[3]) + span_mul(t4, t3, slope_q[4])
              + span_mul((temp_code > TEMP_TOP) ? TEMP_TOP : temp_code, t4,
                         slope_q[5]);                       // [R11]
      end
    end
  end

  // Round half away from zero to whole steps
  assign rnd = (acc >= 0) ? ((acc + 14'sd4) >>> 3)
                          : -((-acc + 14'sd4) >>> 3);       // [R21]

  // Gate offset by enable, supply source, code validity and limit order
  always_comb begin
    if (comp_enable && !ext_supply && temp_valid && limits_ok) // [R05] [R19] [R09]
      off_d = rnd[8:0];                                     // [R18]
    else
      off_d = 9'h000;                                       // [R20]
    sum_d = 10'({1'b0, volt_setting} + {off_d[8], off_d});  // [R18]
  end

  // Multiplex and bias decode
  always_comb begin
    ill_d = 1'b0;
    case (mux_q)
      3'd0: bp_d = 4'd1;                                    // [R13] [R15]
      3'd1: bp_d = 4'd2;
      3'd2: bp_d = 4'd4;
      3'd3: bp_d = 4'd6;
      3'd4: bp_d = 4'd8;
      default: bp_d = 4'd9;                                 // [R13]
    endcase
    case (bias_q)
      2'd0: lv_d = 3'd3;                                    // [R14]
      2'd1: lv_d = 3'd4;
      default: lv_d = 3'd5;
    endcase
    if (mux_q == 3'd0) lv_d = 3'd2;                         // [R14] [R15]
    if (mux_q == 3'd1 && bias_q == 2'd2) ill_d = 1'b1;      // [R16]
    if (mux_q == 3'd3 && bias_q == 2'd0) ill_d = 1'b1;      // [R17]
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      off_q <= 9'h000;
      sum_q <= 10'h000;
      act_q <= 1'b0;
      bp_q  <= 4'd1;
      lv_q  <= 3'd2;
      ill_q <= 1'b0;
    end else begin
      off_q <= off_d;
      sum_q <= sum_d;
      act_q <= comp_enable && !ext_supply && temp_valid && limits_ok;
      bp_q  <= bp_d;
      lv_q  <= lv_d;
      ill_q <= ill_d;
    end
  end

  assign comp_offset     = off_q;
  assign supply_target   = sum_q;
  assign comp_active     = act_q;
  assign backplane_count = bp_q;
  assign drive_levels    = lv_q;
  assign static_drive    = (bp_q == 4'd1);
  assign bias_illegal    = ill_q;
endmodule // ltc_top

//--- logic/ltc_pkg.sv
// Package for the LCD temperature compensation block.
// Assumes a single 100 MHz clock domain.
package ltc_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned PERIOD_MS       = 1000;     // Measurement repeat period, ms
  localparam int unsigned CONV_MS         = 8;        // Conversion time, ms
  localparam int unsigned PERIOD_CYC      = CLK_HZ / 1000 * PERIOD_MS;
  localparam int unsigned CONV_CYC        = CLK_HZ / 1000 * CONV_MS;
  // Temperature code values
  localparam logic [7:0]  TEMP_RESET      = 8'hff;    // No measurement available
  localparam logic [7:0]  TEMP_MID        = 8'h60;    // 96, zero offset point
  localparam logic [7:0]  TEMP_TOP        = 8'he7;    // 231
  localparam logic [7:0]  LOW_BASE        = 8'h0a;    // 10
  localparam logic [7:0]  LOW_STEP        = 8'h0a;    // 10
  localparam logic [7:0]  HIGH_BASE       = 8'h6e;    // 110
  localparam logic [7:0]  HIGH_STEP       = 8'h0e;    // 14
  localparam logic [2:0]  SLOPE_RESET     = 3'h0;
  localparam logic [2:0]  LIMIT_RESET     = 3'h0;
  // Slope coefficients in eighths
  localparam logic signed [4:0] COEF_TAB [8] = '{5'sh00, -5'sh01, -5'sh02, -5'sh04,
                                                 -5'sh0a, 5'sh01, 5'sh02, 5'sh04};
  // Multiplex modes
  typedef enum logic [2:0] {
    LTC_MUX_STATIC, LTC_MUX_2, LTC_MUX_4, LTC_MUX_6, LTC_MUX_8, LTC_MUX_9
  } ltc_mux_t;
  // Bias settings
  typedef enum logic [1:0] {
    LTC_BIAS_HALF, LTC_BIAS_THIRD, LTC_BIAS_QUARTER
  } ltc_bias_t;
  localparam logic [2:0] MUX_RESET  = 3'h0;
  localparam logic [1:0] BIAS_RESET = 2'h0;
endpackage

//--- logic/ltc_sensor.sv
// Measurement sequencer and optional smoothing filter for the temperature code.
// Assumes raw sensor code is synchronous to clk.
`timescale 1ns/1ns
module ltc_sensor
  import ltc_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC,
  parameter int unsigned CONV_CYCLES   = CONV_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       measure_enable,
  input  wire logic       temp_filter_enable,
  // Analog sensor side
  input  wire logic [7:0] sensor_raw,
  output logic            sensor_start,
  // Result
  output logic [7:0]      temp_code,
  output logic            temp_valid,
  output logic            meas_done
);
  // Refuse counts the sequencer cannot serve
  if (CONV_CYCLES < 1 || PERIOD_CYCLES <= CONV_CYCLES) begin : g_bad_cfg
    $error("ltc_sensor: period must exceed conversion time");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} ltc_st_t;
  ltc_st_t     st_q;
  logic [31:0] cnt_q;
  logic [7:0]  code_q;
  logic        valid_q;
  logic        done_q;
  logic        start_q;
  logic [8:0]  avg;

  // Filter: average of previous and new code damps oscillation
  assign avg = ({1'b0, code_q} + {1'b0, sensor_raw} + 9'h001) >> 1;

  // Repeat measurement each period while enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 32'h0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (st_q)
        ST_IDLE: if (measure_enable) begin                      // [R03]
          st_q    <= ST_CONV;
          cnt_q   <= 32'h0;
          start_q <= 1'b1;
        end
        ST_CONV: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == CONV_CYCLES - 1) st_q <= ST_WAIT;        // [R03]
        end
        ST_WAIT: begin
          cnt_q <= cnt_q + 32'h1;
          // Restart directly so starts stay exactly one period apart
          if (cnt_q == PERIOD_CYCLES - 1) begin                 // [R03]
            st_q    <= measure_enable ? ST_CONV : ST_IDLE;
            cnt_q   <= 32'h0;
            start_q <= measure_enable;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Result register, FFh until first measurement
  always_ff @(posedge clk) begin
    if (rst) begin
      code_q  <= TEMP_RESET;                                    // [R02]
      valid_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (st_q == ST_CONV && cnt_q == CONV_CYCLES - 1) begin
        done_q  <= 1'b1;
        valid_q <= 1'b1;
        if (temp_filter_enable && valid_q) code_q <= avg[7:0];  // [R04]
        else code_q <= sensor_raw;                              // [R01]
      end
    end
  end

  assign temp_code    = code_q;
  assign temp_valid   = valid_q && (code_q != TEMP_RESET);
  assign meas_done    = done_q;
  assign sensor_start = start_q;
endmodule // ltc_sensor

//--- dv/ltc_top_monitor.sv
// Port checker for ltc_top: measurement timing, offset gating, selector decode.
// Bound into ltc_top below; one clock with synchronous active-high reset.
`timescale 1ns/1ns
module ltc_top_check
  import ltc_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC,
  parameter int unsigned CONV_CYCLES   = CONV_CYC
) (
  // Clock, reset and controls
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       comp_enable,
  input wire logic       ext_supply,
  input wire logic [8:0] volt_setting,
  input wire logic       multiplex_select_cmd,
  input wire logic [2:0] multiplex_mode,
  input wire logic       bias_select_cmd,
  input wire logic [1:0] bias_mode,
  // Results
  input wire logic       sensor_start,
  input wire logic [7:0] temp_code,
  input wire logic       temp_valid,
  input wire logic       meas_done,
  input wire logic [8:0] comp_offset,
  input wire logic [9:0] supply_target,
  input wire logic       comp_active,
  input wire logic [3:0] backplane_count,
  input wire logic [2:0] drive_levels,
  input wire logic       static_drive,
  input wire logic       bias_illegal
);
  logic [31:0] gap_q;
  logic        seen_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the last conversion start
  always_ff @(posedge clk) begin
    gap_q  <= (rst || sensor_start) ? 32'h0 : gap_q + 32'h1;
    seen_q <= !rst && (seen_q || sensor_start);
  end
  // Result arrives a fixed count after the start
  sequence conv_end_s;
    seen_q && gap_q == CONV_CYCLES - 1;
  endsequence
  start_done_a: assert property (conv_end_s |-> meas_done)
    else $error("conversion result late or missing");
  done_pulse_a: assert property (meas_done |=> !meas_done)
    else $error("done pulse too long");
  period_gap_a: assert property (sensor_start && seen_q |-> gap_q >= PERIOD_CYCLES - 1)
    else $error("measurements too close");
  reset_code_a: assert property ($past(rst) |-> temp_code == TEMP_RESET && !temp_valid)
    else $error("code not empty after reset");
  valid_code_a: assert property (temp_valid |-> temp_code != TEMP_RESET)
    else $error("valid flag with empty code");
  code_hold_a: assert property ($changed(temp_code) |-> meas_done)
    else $error("code changed without a measurement");
  off_gate_a: assert property (
    $past(!comp_enable || ext_supply || !temp_valid) |-> comp_offset == 9'h0 && !comp_active)
    else $error("offset applied while gated off");
  target_sum_a: assert property (!$past(rst) |->
    supply_target == 10'({1'b0, $past(volt_setting)} + {comp_offset[8], comp_offset}))
    else $error("target is not setting plus offset");
  static_lv_a: assert property (static_drive |-> drive_levels == 3'h2 && backplane_count == 4'h1)
    else $error("static drive decode wrong");
  mux_six_a: assert property (multiplex_select_cmd && multiplex_mode == 3'h3 |->
    ##2 backplane_count == 4'h6)
    else $error("six backplane mode not applied");
  quarter_lv_a: assert property (bias_select_cmd && bias_mode == 2'h2 |->
    ##2 (static_drive || drive_levels == 3'h5))
    else $error("quarter bias not five levels");
  bias_flag_a: assert property (bias_illegal |-> (backplane_count == 4'h2 && drive_levels == 3'h5) ||
    (backplane_count == 4'h6 && drive_levels == 3'h3))
    else $error("bias flag on a supported pair");
endmodule // ltc_top_check
bind ltc_top ltc_top_check #(.PERIOD_CYCLES(PERIOD_CYCLES), .CONV_CYCLES(CONV_CYCLES)) ltc_top_check_inst (
  .clk, .rst, .comp_enable, .ext_supply, .volt_setting, .multiplex_select_cmd, .multiplex_mode,
  .bias_select_cmd, .bias_mode, .sensor_start, .temp_code, .temp_valid, .meas_done, .comp_offset,
  .supply_target, .comp_active, .backplane_count, .drive_levels, .static_drive, .bias_illegal);

//--- dv/ltc_sensor_model.sv
// Behavioural temperature sensor answering each conversion start.
// Assumes the bench sets meas_val before the start pulse.
`timescale 1ns/1ns
module ltc_sensor_model #(
  parameter int unsigned CONV_CYCLES = 5
) (
  // Clock and start
  input  wire logic       clk,
  input  wire logic       sensor_start,
  // Code to report and raw output
  input  wire logic [7:0] meas_val,
  output logic      [7:0] sensor_raw
);
  int unsigned cnt_q = 1000;
  logic [7:0]  raw_q = 8'h5a;
  // Code latched at start, held through conversion, then toggling
  always_ff @(posedge clk) begin
    cnt_q <= sensor_start ? 0 : cnt_q + 32'(cnt_q < 1000);
    raw_q <= sensor_start ? meas_val : (cnt_q < CONV_CYCLES + 2 ? raw_q : ~raw_q);
  end
  assign sensor_raw = raw_q;
endmodule // ltc_sensor_model

//--- dv/test_lcd_temp_compensation.sv
// Self-checking bench for ltc_top with a behavioural sensor.
// Assumes shortened measurement counts; inputs change at falling edges.
`timescale 1ns/1ns
module test_lcd_temp_compensation;
  import ltc_pkg::*;
  logic       clk = 0, rst = 1, measure_enable = 0, temp_filter_enable = 0;
  logic       comp_enable = 0, ext_supply = 0, set_limit_cmd = 0, set_slope_cmd = 0;
  logic       multiplex_select_cmd = 0, bias_select_cmd = 0;
  logic [1:0] set_limit_sel = 0, bias_mode = 0;
  logic [2:0] set_limit_code = 0, set_slope_sel = 0, set_slope_code = 0, multiplex_mode = 0;
  logic [8:0] volt_setting = 9'h0f0, comp_offset;
  logic [7:0] meas_val = 8'h00, sensor_raw, temp_code;
  logic       sensor_start, temp_valid, meas_done, comp_active, static_drive, bias_illegal;
  logic [9:0] supply_target;
  logic [3:0] backplane_count;
  logic [2:0] drive_levels;
  int n_mismatch = 0, cmp_count = 0, et = 255;
  int lim[4] = '{10, 10, 110, 110};
  int slp[6] = '{0, 0, 0, 0, 0, 0};
  int cf[8] = '{0, -1, -2, -4, -10, 1, 2, 4};
  ltc_top #(.PERIOD_CYCLES(50), .CONV_CYCLES(5)) ltc_top_inst (.clk, .rst, .measure_enable,
    .temp_filter_enable, .comp_enable, .ext_supply, .set_limit_cmd, .set_limit_sel,
    .set_limit_code, .set_slope_cmd, .set_slope_sel, .set_slope_code, .volt_setting,
    .multiplex_select_cmd, .multiplex_mode, .bias_select_cmd, .bias_mode, .sensor_raw,
    .sensor_start, .temp_code, .temp_valid, .meas_done, .comp_offset, .supply_target,
    .comp_active, .backplane_count, .drive_levels, .static_drive, .bias_illegal);
  ltc_sensor_model #(.CONV_CYCLES(5)) ltc_sensor_model_inst (.clk, .sensor_start, .meas_val,
    .sensor_raw);
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input int exp, input string what);
    cmp_count++;
    if (got !== 16'(exp)) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, 16'(exp));
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One-cycle strobe, then an idle cycle so strobes never merge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask
  task automatic set_lim(input int s, input int c);
    set_limit_sel = 2'(s);
    set_limit_code = 3'(c);
    pulse(set_limit_cmd);
    lim[s] = s < 2 ? 10 + 10 * c : 110 + 14 * c;
  endtask
  task automatic set_slp(input int s, input int c);
    set_slope_sel = 3'(s);
    set_slope_code = 3'(c);
    pulse(set_slope_cmd);
    if (s < 6) slp[s] = c;
  endtask
  function automatic int clip(int x, int lo, int hi);
    return x < lo ? lo : (x > hi ? hi : x);
  endfunction
  // Expected offset in eighths, rounded half away from zero
  function automatic logic [8:0] eoff();
    int c, s;
    c = clip(et, 0, 231);
    s = cf[slp[3]] * (clip(c, 96, lim[2]) - 96) + cf[slp[4]] * (clip(c, lim[2], lim[3]) - lim[2])
      + cf[slp[5]] * (clip(c, lim[3], 231) - lim[3]) - cf[slp[2]] * (96 - clip(c, lim[1], 96))
      - cf[slp[1]] * (lim[1] - clip(c, lim[0], lim[1])) - cf[slp[0]] * (lim[0] - clip(c, 0, lim[0]));
    if (!comp_enable || ext_supply || et == 255 || lim[0] >= lim[1] || lim[2] >= lim[3]) s = 0;
    return 9'(s >= 0 ? (s + 4) / 8 : -((4 - s) / 8));
  endfunction
  task automatic chk_off();
    logic [8:0] e;
    logic       a;
    cyc(3);
    e = eoff();
    a = comp_enable && !ext_supply && et != 255 && lim[0] < lim[1] && lim[2] < lim[3];
    chk(comp_active, a, "active");
    chk(comp_offset, e, "offset");
    chk(supply_target, 10'({1'b0, volt_setting} + {e[8], e}), "target");
  endtask
  task automatic measure(input int v);
    int k;
    meas_val = 8'(v);
    for (k = 0; k < 200 && sensor_start !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 20 && meas_done !== 1'b1; k++) @(negedge clk);
    chk(meas_done, 1, "done");
    et = temp_filter_enable && et != 255 ? (et + v + 1) / 2 : v;
    chk(temp_code, et, "code");
    chk(temp_valid, 1, "valid");
  endtask
  task automatic t_reset();
    chk(temp_code, 255, "reset code");
    chk(temp_valid, 0, "reset valid");
    chk(backplane_count, 1, "reset backplanes");
    chk(drive_levels, 2, "reset levels");
    chk_off();
  endtask
  task automatic t_comp();
    measure_enable = 1;
    comp_enable = 1;
    measure(96);
    chk_off();
    set_lim(0, 1);
    set_lim(1, 5);
    set_lim(2, 2);
    set_lim(3, 6);
    for (int i = 0; i < 6; i++) set_slp(i, (i + 2) % 8);
    foreach (cf[i]) begin
      measure(i == 0 ? 0 : 33 * i);
      chk_off();
    end
    set_slp(6, 3);
    set_slp(0, 0);
    set_slp(1, 1);
    measure(5);
    chk_off();
    set_lim(1, 7);
    for (int k = 0; k < 8; k++) begin
      set_lim(0, k);
      chk_off();
    end
    set_lim(0, 1);
    measure(240);
    set_lim(3, 7);
    for (int k = 0; k < 8; k++) begin
      set_lim(2, k);
      chk_off();
    end
  endtask
  task automatic t_gate();
    // Ordered limits again, so gating is the only thing zeroing the offset
    set_lim(2, 2);
    comp_enable = 0;
    chk_off();
    comp_enable = 1;
    ext_supply = 1;
    chk_off();
    ext_supply = 0;
    chk_off();
    temp_filter_enable = 1;
    measure(128);
    measure(16);
  endtask
  task automatic t_mux();
    int bpn[6] = '{1, 2, 4, 6, 8, 9};
    int em, eb;
    for (int m = 0; m < 7; m++)
      for (int b = 0; b < 4; b++) begin
        // Mode 6 and bias 3 are refused, so the last legal values remain
        em = m > 5 ? 5 : m;
        eb = b > 2 ? 2 : b;
        multiplex_mode = 3'(m);
        bias_mode = 2'(b);
        pulse(multiplex_select_cmd);
        pulse(bias_select_cmd);
        cyc(2);
        chk(backplane_count, bpn[em], "backplanes");
        chk(static_drive, em == 0, "static");
        chk(drive_levels, em == 0 ? 2 : eb + 3, "levels");
        chk(bias_illegal, (em == 1 && eb == 2) || (em == 3 && eb == 0), "bias flag");
        if (b == 3) continue;
        bias_mode = 2'(b);
        pulse(bias_select_cmd);
        cyc(2);
        chk(drive_levels, em == 0 ? 2 : b + 3, "levels");
        chk(bias_illegal, (em == 1 && b == 2) || (em == 3 && b == 0), "bias flag");
      end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(16);
    rst = 0;
    cyc(1);
    t_reset();
    t_comp();
    t_gate();
    t_mux();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // test_lcd_temp_compensation
